/* File: ddl_host.sv */
// Host serial port model that drives frames into the converter control
`timescale 1ns/10ps
module ddl_host (
	output logic o_sync_n,
	output logic o_sclk,
	output logic o_din
);
	initial begin
		o_sync_n = 1'b1;
		o_sclk = 1'b1;
		o_din = 1'b0;
	end
	task automatic send(input logic [23:0] w, input int nbits);
		o_sync_n = 1'b0;
		#200;
		for (int i = 23; i > 23 - nbits; i--) begin
			o_din = w[i];
			#100;
			o_sclk = 1'b0;
			#200;
			o_sclk = 1'b1;
			#100;
		end
		o_sync_n = 1'b1;
		// Released data line must not keep showing the last bit
		o_din = ~o_din;
		#400;
	endtask : send
endmodule : ddl_host

/* File: ddl_pkg.sv */
// Constants and types for the dual converter serial load control
package ddl_pkg;
	localparam int FRAME_BITS = 24;
	localparam int CNT_W = 5;
	localparam logic [CNT_W-1:0] CNT_LAST = 5'h17;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam int DATA_W = 16;
	localparam int CH_NUM = 2;
	localparam int CMD_MSB = 21;
	localparam int CMD_LSB = 19;
	localparam int ADDR_MSB = 18;
	localparam int ADDR_LSB = 16;
	localparam int FIFO_DEPTH = 16;
	localparam logic [DATA_W-1:0] ZERO_CODE = 16'h0000;
	localparam logic [CH_NUM-1:0] MASK_RESET = 2'h0;
	localparam logic [2:0] CMD_WR_INPUT = 3'h0;
	localparam logic [2:0] CMD_UPD_ONE = 3'h1;
	localparam logic [2:0] CMD_WR_UPD_ALL = 3'h2;
	localparam logic [2:0] CMD_WR_UPD_ONE = 3'h3;
	localparam logic [2:0] CMD_POWER = 3'h4;
	localparam logic [2:0] CMD_RESET = 3'h5;
	localparam logic [2:0] CMD_MASK = 3'h6;
	localparam logic [2:0] ADDR_A = 3'h0;
	localparam logic [2:0] ADDR_B = 3'h1;
	localparam logic [2:0] ADDR_ALL = 3'h7;
	typedef enum logic {RX_IDLE, RX_SHIFT} ddl_rx_state_t;
endpackage : ddl_pkg

/* File: ddl_top.sv */
// Serial frame receiver, frame FIFO and converter register control
`timescale 1ns/10ps

module ddl_pin_sync #(
	parameter logic INIT = 1'b1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_pin,
	output logic o_level
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg;
	// A change is taken only once the last two stages agree
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			lvl_reg <= INIT;
		end else begin
			s1_reg <= i_pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			lvl_reg <= (s2_reg == s3_reg) ? s3_reg : lvl_reg;
		end
	end
	assign o_level = lvl_reg;
endmodule : ddl_pin_sync

module ddl_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_flush,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
	logic [AW-1:0] wr_reg, rd_reg;
	logic [AW:0] cnt_reg;
	wire wr_en = i_valid && o_ready;
	wire rd_en = o_valid && i_ready;
	// Count is one bit wider than the pointers, so full shows as DEPTH itself
	assign o_ready = (cnt_reg != (AW+1)'(DEPTH));
	assign o_valid = (cnt_reg != '0);
	assign o_data = mem_reg[rd_reg];
	always_ff @(posedge i_clk) begin
		if (wr_en) begin
			mem_reg[wr_reg] <= i_data;
		end
	end
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || i_flush) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_en ? wr_reg + 1'b1 : wr_reg;
			rd_reg <= rd_en ? rd_reg + 1'b1 : rd_reg;
			cnt_reg <= cnt_reg + {{AW{1'b0}}, wr_en} - {{AW{1'b0}}, rd_en};
		end
	end
endmodule : ddl_fifo

module ddl_top
	import ddl_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sync_n,
	input wire logic i_sclk,
	input wire logic i_din,
	input wire logic i_load_strobe_n,
	input wire logic i_async_clear_n,
	input wire logic i_exec_hold,
	output logic [DATA_W-1:0] o_dac_a,
	output logic [DATA_W-1:0] o_dac_b,
	output logic [DATA_W-1:0] o_power_word,
	output logic [CH_NUM-1:0] o_load_mask,
	output logic o_cleared,
	output logic o_rx_ready
);
	logic sync_lvl, sclk_lvl, din_lvl, load_lvl, clr_lvl;
	logic sync_prev_reg, sclk_prev_reg, clr_prev_reg;
	ddl_rx_state_t state_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [FRAME_BITS-1:0] shift_reg;
	logic push_reg, cleared_reg, rx_ready_reg;
	logic [DATA_W-1:0] inp_reg [0:CH_NUM-1];
	logic [DATA_W-1:0] dac_reg [0:CH_NUM-1];
	logic [DATA_W-1:0] inp_w [0:CH_NUM-1];
	logic [DATA_W-1:0] power_reg;
	logic [CH_NUM-1:0] mask_reg, sel, upd, follow;
	logic fifo_in_ready, fifo_valid;
	logic [FRAME_BITS-1:0] fifo_data;

	ddl_pin_sync #(.INIT(1'b1)) u_sync (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_sync_n),
		.o_level(sync_lvl));
	ddl_pin_sync #(.INIT(1'b1)) u_sclk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_sclk),
		.o_level(sclk_lvl));
	ddl_pin_sync #(.INIT(1'b0)) u_din (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_pin(i_din),
		.o_level(din_lvl));
	ddl_pin_sync #(.INIT(1'b1)) u_load (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_pin(i_load_strobe_n), .o_level(load_lvl));
	ddl_pin_sync #(.INIT(1'b1)) u_clr (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_pin(i_async_clear_n), .o_level(clr_lvl));

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sync_prev_reg <= 1'b1;
			sclk_prev_reg <= 1'b1;
			clr_prev_reg <= 1'b1;
		end else begin
			sync_prev_reg <= sync_lvl;
			sclk_prev_reg <= sclk_lvl;
			clr_prev_reg <= clr_lvl;
		end
	end

	wire sync_fall = sync_prev_reg && !sync_lvl;
	wire sync_rise = !sync_prev_reg && sync_lvl;
	wire sclk_fall = sclk_prev_reg && !sclk_lvl;
	// clear zeroes and flushes on its fall; its low level also blocks the load strobe
	wire clr_fall = clr_prev_reg && !clr_lvl;
	wire last_bit = (cnt_reg == CNT_LAST);

	// Frame receiver; sync fall beats a coincident clock edge
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			state_reg <= RX_IDLE;
			cnt_reg <= CNT_ZERO;
			shift_reg <= '0;
			push_reg <= 1'b0;
		end else begin
			push_reg <= 1'b0;
			if (clr_fall) begin
				state_reg <= RX_IDLE;
			end else if (sync_fall) begin
				state_reg <= RX_SHIFT;
				cnt_reg <= CNT_ZERO;
			end else if (state_reg == RX_SHIFT) begin
				if (sync_rise) begin
					state_reg <= RX_IDLE;
				end else if (sclk_fall) begin
					shift_reg <= {shift_reg[FRAME_BITS-2:0], din_lvl};
					cnt_reg <= cnt_reg + 1'b1;
					if (last_bit) begin
						push_reg <= 1'b1;
						state_reg <= RX_IDLE;
					end
				end
			end
		end
	end

	// Pending frames are flushed by clear, so none of them executes after it
	ddl_fifo #(.WIDTH(FRAME_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_flush(clr_fall),
		.i_valid(push_reg),
		.o_ready(fifo_in_ready),
		.i_data(shift_reg),
		.o_valid(fifo_valid),
		.i_ready(!i_exec_hold),
		.o_data(fifo_data)
	);

	wire [2:0] cmd = fifo_data[CMD_MSB:CMD_LSB];
	wire [2:0] addr = fifo_data[ADDR_MSB:ADDR_LSB];
	wire [DATA_W-1:0] data = fifo_data[DATA_W-1:0];
	// execute completed frame
	// Clear wins over a same-cycle execute, so power and mask stay untouched too
	wire exec_fire = fifo_valid && !i_exec_hold && !clr_fall;
	wire do_write = (cmd == CMD_WR_INPUT) || (cmd == CMD_WR_UPD_ALL) || (cmd == CMD_WR_UPD_ONE);
	wire upd_sel = (cmd == CMD_UPD_ONE) || (cmd == CMD_WR_UPD_ONE);
	wire upd_all = (cmd == CMD_WR_UPD_ALL);
	wire do_reset = exec_fire && (cmd == CMD_RESET);
	wire do_power = exec_fire && (cmd == CMD_POWER);
	wire do_mask = exec_fire && (cmd == CMD_MASK);
	wire ld_active = !load_lvl && clr_lvl;
	assign sel[0] = (addr == ADDR_A) || (addr == ADDR_ALL);
	assign sel[1] = (addr == ADDR_B) || (addr == ADDR_ALL);

	for (genvar ch = 0; ch < CH_NUM; ch++) begin : g_ch
		assign inp_w[ch] = (exec_fire && do_write && sel[ch]) ? data : inp_reg[ch];
		assign upd[ch] = exec_fire && (upd_all || (upd_sel && sel[ch]));
		assign follow[ch] = ld_active || mask_reg[ch];
		always_ff @(posedge i_clk) begin
			if (!i_rst_n || clr_fall || do_reset) begin
				inp_reg[ch] <= ZERO_CODE;
				dac_reg[ch] <= ZERO_CODE;
			end else begin
				inp_reg[ch] <= inp_w[ch];
				dac_reg[ch] <= upd[ch] ? inp_w[ch] : (follow[ch] ? inp_reg[ch] : dac_reg[ch]);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n || do_reset) begin
			power_reg <= ZERO_CODE;
			mask_reg <= MASK_RESET;
		end else begin
			power_reg <= do_power ? data : power_reg;
			mask_reg <= do_mask ? data[CH_NUM-1:0] : mask_reg;
		end
	end

	// clear mode until frame; set wins
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			cleared_reg <= 1'b0;
			rx_ready_reg <= 1'b1;
		end else begin
			cleared_reg <= clr_fall || (cleared_reg && !exec_fire);
			rx_ready_reg <= fifo_in_ready;
		end
	end

	assign o_dac_a = dac_reg[0];
	assign o_dac_b = dac_reg[1];
	assign o_power_word = power_reg;
	assign o_load_mask = mask_reg;
	assign o_cleared = cleared_reg;
	assign o_rx_ready = rx_ready_reg;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	property p_clear_zero;
		clr_fall |=> (dac_reg[0] == ZERO_CODE) && (dac_reg[1] == ZERO_CODE)
			&& (inp_reg[0] == ZERO_CODE) && (inp_reg[1] == ZERO_CODE) && cleared_reg;
	endproperty
	a_clear_zero: assert property (p_clear_zero) else $error("clear did not zero");
	property p_clear_abort;
		clr_fall |=> state_reg == RX_IDLE ##1 !push_reg;
	endproperty
	a_clear_abort: assert property (p_clear_abort) else $error("frame not aborted");
	property p_clr_ignore_load;
		!clr_lvl && !clr_fall && !exec_fire && (mask_reg == MASK_RESET)
			|=> $stable(dac_reg[0]) && $stable(dac_reg[1]);
	endproperty
	a_clr_ignore_load: assert property (p_clr_ignore_load) else $error("load in clear");
	property p_load_follow;
		ld_active && !exec_fire && !clr_fall |=> dac_reg[1] == $past(inp_reg[1]);
	endproperty
	a_load_follow: assert property (p_load_follow) else $error("no load copy");
	property p_no_update;
		load_lvl && !exec_fire && !clr_fall && !mask_reg[0] |=> $stable(dac_reg[0]);
	endproperty
	a_no_update: assert property (p_no_update) else $error("stray update");
	property p_arm;
		sync_fall && !clr_fall |=> state_reg == RX_SHIFT && cnt_reg == CNT_ZERO;
	endproperty
	a_arm: assert property (p_arm) else $error("sync fall did not arm");
	property p_partial;
		state_reg == RX_SHIFT && sync_rise && !sync_fall |=> state_reg == RX_IDLE ##1 !push_reg;
	endproperty
	a_partial: assert property (p_partial) else $error("partial frame kept");
	property p_complete;
		state_reg == RX_SHIFT && sclk_fall && last_bit && !sync_rise && !sync_fall && !clr_fall
			|=> push_reg && shift_reg[0] == $past(din_lvl) && state_reg == RX_IDLE;
	endproperty
	a_complete: assert property (p_complete) else $error("24th edge lost");
	property p_wr_upd;
		exec_fire && !clr_fall && cmd == CMD_WR_UPD_ONE && addr == ADDR_A
			|=> dac_reg[0] == $past(data) && inp_reg[0] == $past(data);
	endproperty
	a_wr_upd: assert property (p_wr_upd) else $error("write update wrong");
	property p_exit_clear;
		cleared_reg && exec_fire && !clr_fall |=> !cleared_reg;
	endproperty
	a_exit_clear: assert property (p_exit_clear) else $error("clear mode stuck");

	c_frame: cover property (push_reg ##[1:4] exec_fire);
	c_partial: cover property (state_reg == RX_SHIFT && sync_rise);
	c_load_pulse: cover property (ld_active ##1 !ld_active);
	c_clear_mid: cover property (state_reg == RX_SHIFT && clr_fall);
endmodule : ddl_top

/* File: ddl_top_tb_top.sv */
// Self-checking bench for the dual converter serial load control
`timescale 1ns/10ps
module ddl_top_tb_top;
	import ddl_pkg::*;
	logic i_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_load_strobe_n = 1'b1;
	logic i_async_clear_n = 1'b1;
	logic i_exec_hold = 1'b0;
	logic sync_n, sclk, din;
	logic [DATA_W-1:0] o_dac_a, o_dac_b, o_power_word;
	logic [CH_NUM-1:0] o_load_mask;
	logic o_cleared, o_rx_ready;
	logic [DATA_W-1:0] inr [2];
	logic [DATA_W-1:0] dac [2];
	logic [DATA_W-1:0] pw = '0;
	logic [CH_NUM-1:0] msk = '0;
	logic clr_exp = 1'b0;
	logic [DATA_W-1:0] d;
	int failures = 0;
	int num_checks = 0;
	int seed = 32'h1f1396c8;
	always #25 i_clk = ~i_clk;
	ddl_host u_ddl_host (.o_sync_n(sync_n), .o_sclk(sclk), .o_din(din));
	ddl_top u_ddl_top (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sync_n(sync_n), .i_sclk(sclk),
		.i_din(din), .i_load_strobe_n(i_load_strobe_n), .i_async_clear_n(i_async_clear_n),
		.i_exec_hold(i_exec_hold), .o_dac_a(o_dac_a), .o_dac_b(o_dac_b),
		.o_power_word(o_power_word), .o_load_mask(o_load_mask), .o_cleared(o_cleared),
		.o_rx_ready(o_rx_ready));
	task automatic conclude();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : cyc
	task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : check
	task automatic check_all();
		check("dac_a", dac[0], o_dac_a);
		check("dac_b", dac[1], o_dac_b);
		check("power_word", pw, o_power_word);
		check("load_mask", {14'h0, msk}, {14'h0, o_load_mask});
		check("cleared", {15'h0, clr_exp}, {15'h0, o_cleared});
	endtask : check_all
	task automatic zero();
		for (int i = 0; i < 2; i++) begin
			inr[i] = '0;
			dac[i] = '0;
		end
		clr_exp = 1'b1;
	endtask : zero
	task automatic model(input logic [2:0] c, input logic [2:0] a, input logic [15:0] v);
		logic [1:0] s;
		s = (a == ADDR_ALL) ? 2'h3 : (a == ADDR_A) ? 2'h1 : (a == ADDR_B) ? 2'h2 : 2'h0;
		if (c == CMD_RESET) begin
			zero();
			pw = '0;
			msk = '0;
		end
		clr_exp = 1'b0;
		if (c == CMD_POWER)
			pw = v;
		if (c == CMD_MASK)
			msk = v[1:0];
		for (int i = 0; i < 2; i++) begin
			if (s[i] && (c == CMD_WR_INPUT || c == CMD_WR_UPD_ALL || c == CMD_WR_UPD_ONE))
				inr[i] = v;
			if (c == CMD_WR_UPD_ALL || (s[i] && (c == CMD_UPD_ONE || c == CMD_WR_UPD_ONE)))
				dac[i] = inr[i];
			if (msk[i] || (!i_load_strobe_n && i_async_clear_n))
				dac[i] = inr[i];
		end
	endtask : model
	task automatic frame(input logic [2:0] c, input logic [2:0] a, input logic [15:0] v,
		input int n);
		u_ddl_host.send({2'($random(seed)), c, a, v}, n);
		if (n == FRAME_BITS)
			model(c, a, v);
		cyc(4);
		check_all();
	endtask : frame
	task automatic strobe_pulse();
		i_load_strobe_n = 1'b0;
		cyc(6);
		i_load_strobe_n = 1'b1;
		cyc(8);
	endtask : strobe_pulse
	initial begin
		#2_000_000;
		failures++;
		conclude();
	end
	initial begin
		zero();
		clr_exp = 1'b0;
		cyc(12);
		i_rst_n = 1'b1;
		cyc(2);
		check_all();
		check("rx_ready", 16'h1, {15'h0, o_rx_ready});
		for (int k = 0; k < 16; k++)
			frame(3'(k), (k % 3 == 2) ? ADDR_ALL : 3'(k % 3), 16'($random(seed)), 24);
		frame(CMD_MASK, ADDR_A, 16'h0000, 24);
		frame(CMD_WR_INPUT, ADDR_A, 16'($random(seed)), 24);
		frame(CMD_WR_INPUT, ADDR_B, 16'($random(seed)), 24);
		frame(CMD_WR_UPD_ONE, ADDR_A, 16'hffff, 23);
		frame(CMD_WR_UPD_ONE, ADDR_B, 16'h8001, 24);
		strobe_pulse();
		dac[0] = inr[0];
		check_all();
		i_load_strobe_n = 1'b0;
		frame(CMD_WR_INPUT, ADDR_ALL, 16'($random(seed)), 24);
		i_load_strobe_n = 1'b1;
		i_async_clear_n = 1'b0;
		cyc(8);
		zero();
		check_all();
		frame(CMD_WR_INPUT, ADDR_A, 16'h5a5a, 24);
		strobe_pulse();
		check_all();
		i_async_clear_n = 1'b1;
		cyc(8);
		i_async_clear_n = 1'b0;
		cyc(8);
		zero();
		frame(CMD_WR_UPD_ONE, ADDR_A, 16'h1234, 23);
		frame(CMD_POWER, ADDR_A, 16'h00f0, 24);
		i_async_clear_n = 1'b1;
		cyc(8);
		fork
			u_ddl_host.send({2'h0, CMD_WR_UPD_ONE, ADDR_A, 16'hc3c3}, 24);
			begin
				cyc(80);
				i_async_clear_n = 1'b0;
			end
		join
		zero();
		cyc(8);
		check_all();
		i_async_clear_n = 1'b1;
		i_exec_hold = 1'b1;
		for (int k = 0; k < FIFO_DEPTH + 1; k++)
			u_ddl_host.send({2'h0, CMD_WR_INPUT, ADDR_A, 16'(k * 16'h0101)}, 24);
		check("rx_ready", 16'h0, {15'h0, o_rx_ready});
		i_exec_hold = 1'b0;
		cyc(60);
		model(CMD_WR_INPUT, ADDR_A, 16'(15 * 16'h0101));
		check("rx_ready", 16'h1, {15'h0, o_rx_ready});
		frame(CMD_UPD_ONE, ADDR_A, 16'h0000, 24);
		conclude();
	end
endmodule : ddl_top_tb_top
